// ==== hw/status_sel_pkg.sv ====
// constants and helpers for the drive status output selection block
package status_sel_pkg;
  // frequencies are held in tenths of a hertz
  localparam int FREQ_W = 16;
  localparam logic [15:0] FREQ_LIMIT = 16'h0fa0;   // 400.0 Hz
  localparam logic [15:0] LEVEL_RST = 16'h012c;    // 30.0 Hz
  localparam logic [15:0] BW_RST = 16'h0064;       // 10.0 Hz
  localparam logic [15:0] MAXF_RST = 16'h0258;     // 60.0 Hz
  localparam logic [4:0] TSEL_RST = 5'h0c;
  localparam logic [4:0] RSEL_RST = 5'h11;
  localparam logic [2:0] FEN_RST = 3'h2;

  // register byte offsets
  localparam logic [7:0] OFS_LEVEL = 8'h00;
  localparam logic [7:0] OFS_BW = 8'h04;
  localparam logic [7:0] OFS_SELECT = 8'h08;
  localparam logic [7:0] OFS_MAXF = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // select register fields
  localparam int TSEL_LSB = 0;
  localparam int RSEL_LSB = 8;
  localparam int FEN_LSB = 16;

  // fault enable bits
  localparam int FEN_LV = 0;
  localparam int FEN_OTHER = 1;
  localparam int FEN_RESTART = 2;

  // condition codes
  localparam int NUM_CODES = 18;
  localparam logic [4:0] CODE_PRESET = 5'h00;
  localparam logic [4:0] CODE_LEVEL_MATCH = 5'h01;
  localparam logic [4:0] CODE_WINDOW = 5'h02;
  localparam logic [4:0] CODE_ABOVE = 5'h03;
  localparam logic [4:0] CODE_ABOVE_INV = 5'h04;
  localparam logic [4:0] CODE_DRIVE_OVERLOAD = 5'h06;
  localparam logic [4:0] CODE_FAULT = 5'h11;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // |a - b| <= bw / 2, kept exact by doubling the left side
  function automatic logic within_half_bw(logic [15:0] a, logic [15:0] b, logic [15:0] bw);
    logic [15:0] d;
    d = (a >= b) ? 16'(a - b) : 16'(b - a);
    return {1'b0, d, 1'b0} <= {2'h0, bw};
  endfunction : within_half_bw

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_strb(logic [31:0] old, logic [31:0] d, logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_strb
endpackage : status_sel_pkg

// ==== hw/drive_status_output_select.sv ====
// drive status output selection with axi4-lite settings registers
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - each output independently selects one condition code from 0 to 17
// - code 17 asserts per enables: bit0 low-voltage trip, bit1 other trip, bit2 restart
// - code 0: |preset - output freq| at most half the bandwidth
// - bandwidth 0..400 Hz, default 10.0, refused above max frequency
// - code 1: preset equals detect level and code 0 true
// - detect level 0..400 Hz, default 30.0, refused above max frequency
// - code 2: |level - run freq| at most half the bandwidth
// - code 3: accel run >= level; decel run > level - bw/2
// - code 4: code 3 thresholds, inverted normally-closed polarity
// - codes 5,6,7 follow motor overload, drive overload, stall flags
// - code 8 follows overvoltage trip
// - code 9 follows undervoltage trip
// - code 10 follows heat-sink overheat protection
// - code 11 follows frequency command loss
// - code 12: run command present and output voltage produced
// - code 13 while stopped; code 14 at constant speed
// - code 16 while waiting for a run command
// - enables 2 with code 17: any trip except low voltage
module drive_status_output_select
  import status_sel_pkg::*;
#(
  parameter logic [15:0] MAX_FREQ_DEFAULT = MAXF_RST
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // frequencies in tenths of a hertz
  input wire logic [15:0] preset_freq,
  input wire logic [15:0] output_freq,
  input wire logic [15:0] run_freq,
  input wire logic accelerating,
  input wire logic decelerating,
  // run state
  input wire logic run_cmd,
  input wire logic output_active,
  input wire logic speed_search,
  input wire logic wait_run_cmd,
  // protection flags
  input wire logic motor_overload_flag,
  input wire logic drive_overload_flag,
  input wire logic stall_active_flag,
  input wire logic overvoltage_trip,
  input wire logic lowvoltage_trip,
  input wire logic other_trip,
  input wire logic heatsink_overheat_flag,
  input wire logic cmd_loss_flag,
  input wire logic [7:0] auto_restart_tries_setting,
  // status outputs
  output logic transistor_status_out,
  output logic relay_status_out
);

  ////////////////////////////////////////////////////////////////////////////
  // settings registers and bus slave

  logic [15:0] level_r, bw_r, maxf_r;
  logic [4:0] tsel_r, rsel_r;
  logic [2:0] fen_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_full_r, w_full_r;
  logic above_r, valid_r;
  logic do_write;
  logic [31:0] wval;
  logic [31:0] old_word;
  logic [1:0] wresp;

  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready = !w_full_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;

  // address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_full_r <= 1'b0;
      end
    end
  end

  always_comb begin
    old_word = 32'h0000_0000;
    unique case (awaddr_r)
      OFS_LEVEL: old_word = {16'h0000, level_r};
      OFS_BW: old_word = {16'h0000, bw_r};
      OFS_MAXF: old_word = {16'h0000, maxf_r};
      OFS_SELECT: old_word = {13'h0000, fen_r, 3'h0, rsel_r, 3'h0, tsel_r};
      default: old_word = 32'h0000_0000;
    endcase
    wval = merge_strb(old_word, wdata_r, wstrb_r);
    wresp = RESP_OKAY;
    unique case (awaddr_r)
      // a setting past the top frequency is refused and kept
      OFS_LEVEL: if (wval[31:16] != 16'h0000 || wval[15:0] > FREQ_LIMIT
                     || wval[15:0] > maxf_r) wresp = RESP_SLVERR;
      OFS_BW: if (wval[31:16] != 16'h0000 || wval[15:0] > FREQ_LIMIT
                  || wval[15:0] > maxf_r) wresp = RESP_SLVERR;
      OFS_MAXF: if (wval[31:16] != 16'h0000 || wval[15:0] > FREQ_LIMIT) wresp = RESP_SLVERR;
      OFS_SELECT: if (wval[4:0] >= 5'(NUM_CODES) || wval[12:8] >= 5'(NUM_CODES))
                    wresp = RESP_SLVERR;
      OFS_STATUS: wresp = RESP_SLVERR;
      default: wresp = RESP_DECERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_r <= LEVEL_RST;
      bw_r <= BW_RST;
      maxf_r <= MAX_FREQ_DEFAULT;
      tsel_r <= TSEL_RST;
      rsel_r <= RSEL_RST;
      fen_r <= FEN_RST;
    end else if (do_write && wresp == RESP_OKAY) begin
      unique case (awaddr_r)
        OFS_LEVEL: level_r <= wval[15:0];
        OFS_BW: bw_r <= wval[15:0];
        OFS_MAXF: maxf_r <= wval[15:0];
        OFS_SELECT: begin
          tsel_r <= wval[TSEL_LSB +: 5];
          rsel_r <= wval[RSEL_LSB +: 5];
          fen_r <= wval[FEN_LSB +: 3];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wresp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_LEVEL: s_axi_rdata <= {16'h0000, level_r};
        OFS_BW: s_axi_rdata <= {16'h0000, bw_r};
        OFS_MAXF: s_axi_rdata <= {16'h0000, maxf_r};
        OFS_SELECT: s_axi_rdata <= {13'h0000, fen_r, 3'h0, rsel_r, 3'h0, tsel_r};
        OFS_STATUS: s_axi_rdata <= {29'h0000_0000, above_r, relay_status_out,
                                    transistor_status_out};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_DECERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input sampling

  logic [15:0] preset_r, outf_r, runf_r;
  logic accel_r, decel_r, runcmd_r, active_r, search_r, wait_r;
  logic mol_r, dol_r, stall_r, ov_r, lv_r, oth_r, oh_r, loss_r, restart_r;

  // every condition works from these, one cycle behind the pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      preset_r <= 16'h0000;
      outf_r <= 16'h0000;
      runf_r <= 16'h0000;
      {accel_r, decel_r, runcmd_r, active_r, search_r, wait_r} <= 6'h00;
      {mol_r, dol_r, stall_r, ov_r, lv_r, oth_r, oh_r, loss_r, restart_r} <= 9'h000;
      valid_r <= 1'b0;
    end else begin
      preset_r <= preset_freq;
      outf_r <= output_freq;
      runf_r <= run_freq;
      {accel_r, decel_r, runcmd_r, active_r, search_r, wait_r} <=
        {accelerating, decelerating, run_cmd, output_active, speed_search, wait_run_cmd};
      {mol_r, dol_r, stall_r, ov_r, lv_r, oth_r, oh_r, loss_r} <=
        {motor_overload_flag, drive_overload_flag, stall_active_flag, overvoltage_trip,
         lowvoltage_trip, other_trip, heatsink_overheat_flag, cmd_loss_flag};
      restart_r <= auto_restart_tries_setting != 8'h00;
      valid_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conditions and output selection

  logic [NUM_CODES-1:0] cond;
  logic above_nxt, fault_hit;
  logic transistor_nxt, relay_nxt;

  always_comb begin
    // constant speed keeps the last decision, so the band acts as hysteresis
    above_nxt = above_r;
    if (accel_r) begin
      above_nxt = runf_r >= level_r;
    end else if (decel_r) begin
      above_nxt = ({1'b0, runf_r, 1'b0} + {2'h0, bw_r}) > {1'b0, level_r, 1'b0};
    end
    fault_hit = (fen_r[FEN_LV] && lv_r)
             || (fen_r[FEN_OTHER] && (oth_r || ov_r))
             || (fen_r[FEN_RESTART] && restart_r && (lv_r || oth_r || ov_r));
    cond[0] = within_half_bw(preset_r, outf_r, bw_r);
    cond[1] = (preset_r == level_r) && cond[0];
    cond[2] = within_half_bw(level_r, runf_r, bw_r);
    cond[3] = above_nxt;
    cond[4] = !above_nxt;
    cond[5] = mol_r;
    cond[6] = dol_r;
    cond[7] = stall_r;
    cond[8] = ov_r;
    cond[9] = lv_r;
    cond[10] = oh_r;
    cond[11] = loss_r;
    cond[12] = runcmd_r && active_r;
    cond[13] = !active_r;
    cond[14] = active_r && !accel_r && !decel_r;
    cond[15] = search_r;
    cond[16] = wait_r;
    cond[17] = fault_hit;
    transistor_nxt = cond[tsel_r];
    relay_nxt = cond[rsel_r];
  end

  // outputs stay off until a full set of inputs has been sampled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transistor_status_out <= 1'b0;
      relay_status_out <= 1'b0;
      above_r <= 1'b0;
    end else if (valid_r) begin
      transistor_status_out <= transistor_nxt;
      relay_status_out <= relay_nxt;
      above_r <= above_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rst_off;
    disable iff (1'b0) !aresetn |=> !transistor_status_out && !relay_status_out;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("outputs not inactive after reset");

  property p_code0;
    valid_r && tsel_r == CODE_PRESET && $stable(tsel_r)
      |=> transistor_status_out == $past(within_half_bw(preset_r, outf_r, bw_r));
  endproperty
  a_code0: assert property (p_code0) else $error("code 0 output wrong");

  property p_code1;
    valid_r && rsel_r == CODE_LEVEL_MATCH && preset_r != level_r |=> !relay_status_out;
  endproperty
  a_code1: assert property (p_code1) else $error("code 1 asserted without level match");

  property p_code2;
    valid_r && tsel_r == CODE_WINDOW && $stable(tsel_r)
      |=> transistor_status_out == $past(within_half_bw(level_r, runf_r, bw_r));
  endproperty
  a_code2: assert property (p_code2) else $error("code 2 output wrong");

  property p_code3;
    valid_r && tsel_r == CODE_ABOVE && accel_r |=> transistor_status_out == $past(runf_r >= level_r);
  endproperty
  a_code3: assert property (p_code3) else $error("code 3 accel threshold wrong");

  property p_code4;
    valid_r && rsel_r == CODE_ABOVE_INV && accel_r && runf_r >= level_r |=> !relay_status_out;
  endproperty
  a_code4: assert property (p_code4) else $error("code 4 polarity wrong");

  property p_code6;
    valid_r && tsel_r == CODE_DRIVE_OVERLOAD && $stable(tsel_r) ##1 $stable(tsel_r)
      |-> transistor_status_out == $past(drive_overload_flag, 2);
  endproperty
  a_code6: assert property (p_code6) else $error("code 6 does not follow flag");

  property p_fault2;
    valid_r && rsel_r == CODE_FAULT && fen_r == 3'h2 && lv_r && !oth_r && !ov_r
      |=> !relay_status_out;
  endproperty
  a_fault2: assert property (p_fault2) else $error("relay fired on low-voltage only");

  property p_fault_lv;
    valid_r && rsel_r == CODE_FAULT && fen_r[FEN_LV] && lv_r |=> relay_status_out;
  endproperty
  a_fault_lv: assert property (p_fault_lv) else $error("low-voltage enable ignored");

  property p_bw_refuse;
    do_write && awaddr_r == OFS_BW && wval[15:0] > maxf_r
      |=> s_axi_bresp == RESP_SLVERR && $stable(bw_r);
  endproperty
  a_bw_refuse: assert property (p_bw_refuse) else $error("bandwidth above max accepted");

  property p_lvl_refuse;
    do_write && awaddr_r == OFS_LEVEL && wval[15:0] > maxf_r |=> $stable(level_r);
  endproperty
  a_lvl_refuse: assert property (p_lvl_refuse) else $error("level above max accepted");

endmodule : drive_status_output_select

`default_nettype wire

// ==== tb/control_seq_model.sv ====
// model of the external control sequence that reads both status terminals
`timescale 1ns/1ps
`default_nettype none

module control_seq_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // terminals read from the drive
  input wire logic transistor_status_out,
  input wire logic relay_status_out,
  // latched terminal states
  output logic [1:0] terminals_r
);
  // the sequence only listens, so it never loads the drive's outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      terminals_r <= 2'h0;
    end else begin
      terminals_r <= {transistor_status_out, relay_status_out};
    end
  end
endmodule : control_seq_model
`default_nettype wire

// ==== tb/tb_drive_status_output_select.sv ====
// self-checking bench for the drive status output selection block
`timescale 1ns/1ps
`default_nettype none

module tb_drive_status_output_select;
  import status_sel_pkg::*;
  typedef struct packed {
    logic [4:0] ts;
    logic [4:0] rs;
    logic [2:0] fen;
    logic [15:0] pf;
    logic [15:0] f;
    logic [13:0] fl;
    logic tr;
    logic [1:0] want;
  } row_t;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [1:0] resp;
  } op_t;
  ////////////////////////////////////////////////////////////////////////
  // fl: accel decel run active search wait mol dol stall ov lv other heat loss
  localparam int N_ROWS = 27;
  localparam row_t ROWS [N_ROWS] = '{
    '{5'h00, 5'h01, 3'h2, 16'h012c, 16'h015e, 14'h0000, 1'h0, 2'h3},
    '{5'h00, 5'h01, 3'h2, 16'h012c, 16'h015f, 14'h0000, 1'h0, 2'h0},
    '{5'h01, 5'h02, 3'h2, 16'h0136, 16'h00fa, 14'h0000, 1'h0, 2'h1},
    '{5'h02, 5'h03, 3'h2, 16'h0000, 16'h00f9, 14'h2000, 1'h0, 2'h0},
    '{5'h03, 5'h04, 3'h2, 16'h0000, 16'h012c, 14'h2000, 1'h0, 2'h2},
    '{5'h03, 5'h04, 3'h2, 16'h0000, 16'h012b, 14'h2000, 1'h0, 2'h1},
    '{5'h03, 5'h04, 3'h2, 16'h0000, 16'h00fb, 14'h1000, 1'h0, 2'h2},
    '{5'h03, 5'h04, 3'h2, 16'h0000, 16'h00fa, 14'h1000, 1'h0, 2'h1},
    '{5'h05, 5'h06, 3'h2, 16'h0000, 16'h0000, 14'h0080, 1'h0, 2'h2},
    '{5'h06, 5'h07, 3'h2, 16'h0000, 16'h0000, 14'h0040, 1'h0, 2'h2},
    '{5'h07, 5'h08, 3'h2, 16'h0000, 16'h0000, 14'h0020, 1'h0, 2'h2},
    '{5'h08, 5'h09, 3'h2, 16'h0000, 16'h0000, 14'h0010, 1'h0, 2'h2},
    '{5'h09, 5'h0a, 3'h2, 16'h0000, 16'h0000, 14'h0008, 1'h0, 2'h2},
    '{5'h0a, 5'h0b, 3'h2, 16'h0000, 16'h0000, 14'h0002, 1'h0, 2'h2},
    '{5'h0b, 5'h0c, 3'h2, 16'h0000, 16'h0000, 14'h0001, 1'h0, 2'h2},
    '{5'h0c, 5'h0d, 3'h2, 16'h0000, 16'h0000, 14'h0c00, 1'h0, 2'h2},
    '{5'h0c, 5'h0d, 3'h2, 16'h0000, 16'h0000, 14'h0800, 1'h0, 2'h1},
    '{5'h0e, 5'h0f, 3'h2, 16'h0000, 16'h0000, 14'h0400, 1'h0, 2'h2},
    '{5'h0e, 5'h0f, 3'h2, 16'h0000, 16'h0000, 14'h2600, 1'h0, 2'h1},
    '{5'h10, 5'h10, 3'h2, 16'h0000, 16'h0000, 14'h0100, 1'h0, 2'h3},
    '{5'h11, 5'h11, 3'h1, 16'h0000, 16'h0000, 14'h0008, 1'h0, 2'h3},
    '{5'h11, 5'h11, 3'h1, 16'h0000, 16'h0000, 14'h0004, 1'h0, 2'h0},
    '{5'h11, 5'h11, 3'h2, 16'h0000, 16'h0000, 14'h0004, 1'h0, 2'h3},
    '{5'h11, 5'h11, 3'h2, 16'h0000, 16'h0000, 14'h0008, 1'h0, 2'h0},
    '{5'h11, 5'h11, 3'h2, 16'h0000, 16'h0000, 14'h0010, 1'h0, 2'h3},
    '{5'h11, 5'h11, 3'h4, 16'h0000, 16'h0000, 14'h0008, 1'h1, 2'h3},
    '{5'h11, 5'h11, 3'h4, 16'h0000, 16'h0000, 14'h0004, 1'h0, 2'h0}
  };
  // read rows carry the expected data in d
  localparam int N_OPS = 15;
  localparam op_t OPS [N_OPS] = '{
    '{1'h0, 8'h00, 32'h0000012c, 4'hf, 2'h0},
    '{1'h0, 8'h04, 32'h00000064, 4'hf, 2'h0},
    '{1'h0, 8'h08, 32'h0002110c, 4'hf, 2'h0},
    '{1'h0, 8'h0c, 32'h00000258, 4'hf, 2'h0},
    '{1'h1, 8'h04, 32'h00000259, 4'hf, 2'h2},
    '{1'h0, 8'h04, 32'h00000064, 4'hf, 2'h0},
    '{1'h1, 8'h04, 32'h00000258, 4'hf, 2'h0},
    '{1'h1, 8'h00, 32'h00000259, 4'hf, 2'h2},
    '{1'h1, 8'h00, 32'h00000090, 4'h1, 2'h0},
    '{1'h0, 8'h00, 32'h00000190, 4'hf, 2'h0},
    '{1'h1, 8'h08, 32'h00000012, 4'hf, 2'h2},
    '{1'h1, 8'h10, 32'h00000000, 4'hf, 2'h2},
    '{1'h0, 8'h14, 32'h00000000, 4'hf, 2'h3},
    '{1'h1, 8'h0c, 32'h00000fa1, 4'hf, 2'h2},
    '{1'h0, 8'h10, 32'h00000003, 4'hf, 2'h0}
  };
  ////////////////////////////////////////////////////////////////////////
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic [15:0] pf = 16'h0000, f = 16'h0000, rf = 16'h0000;
  logic [13:0] fl = 14'h0000;
  logic tr = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, t_out, r_out;
  logic [1:0] bresp, rresp, resp;
  logic [1:0] terms;
  logic [31:0] rdata, rd;
  int n_errors = 0;
  int checked = 0;

  // rows give run and output frequency the same value; a hand test pulls them apart
  drive_status_output_select u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .preset_freq(pf), .output_freq(f), .run_freq(rf),
    .accelerating(fl[13]), .decelerating(fl[12]), .run_cmd(fl[11]),
    .output_active(fl[10]), .speed_search(fl[9]), .wait_run_cmd(fl[8]),
    .motor_overload_flag(fl[7]), .drive_overload_flag(fl[6]), .stall_active_flag(fl[5]),
    .overvoltage_trip(fl[4]), .lowvoltage_trip(fl[3]), .other_trip(fl[2]),
    .heatsink_overheat_flag(fl[1]), .cmd_loss_flag(fl[0]),
    .auto_restart_tries_setting({7'h00, tr}), .transistor_status_out(t_out),
    .relay_status_out(r_out)
  );
  control_seq_model u_seq (
    .aclk(aclk), .aresetn(aresetn), .transistor_status_out(t_out),
    .relay_status_out(r_out), .terminals_r(terms)
  );

  initial begin
    forever #25 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  // handshakes are sampled at the falling edge, where the rising-edge values rest
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_hs, w_hs, b_hs;
    b_hs = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 20 && !b_hs; n++) begin
      @(negedge aclk);
      aw_hs = awvalid && awready === 1'h1;
      w_hs = wvalid && wready === 1'h1;
      b_hs = bvalid === 1'h1;
      resp = bresp;
      @(posedge aclk);
      awvalid <= aw_hs ? 1'h0 : awvalid;
      wvalid <= w_hs ? 1'h0 : wvalid;
      bready <= b_hs ? 1'h0 : bready;
    end
    if (!b_hs) begin
      n_errors++;
      end_of_test();
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    logic ar_hs, r_hs;
    r_hs = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 20 && !r_hs; n++) begin
      @(negedge aclk);
      ar_hs = arvalid && arready === 1'h1;
      r_hs = rvalid === 1'h1;
      resp = rresp;
      rd = rdata;
      @(posedge aclk);
      arvalid <= ar_hs ? 1'h0 : arvalid;
      rready <= r_hs ? 1'h0 : rready;
    end
    if (!r_hs) begin
      n_errors++;
      end_of_test();
    end
  endtask : axi_read

  task automatic run_row(input row_t r);
    axi_write(OFS_SELECT, {13'h0000, r.fen, 3'h0, r.rs, 3'h0, r.ts}, 4'hf);
    check(32'(resp), 32'(RESP_OKAY));
    @(posedge aclk);
    pf <= r.pf;
    f <= r.f;
    rf <= r.f;
    fl <= r.fl;
    tr <= r.tr;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check(32'({t_out, r_out}), 32'(r.want));
    // the sequence latches the terminals one edge later
    @(negedge aclk);
    check(32'(terms), 32'(r.want));
  endtask : run_row
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < N_ROWS; i++) begin
      run_row(ROWS[i]);
    end
    $display("condition table done");
    // code 0 must use output frequency and code 2 run frequency
    axi_write(OFS_SELECT, 32'h0000_0200, 4'hf);
    check(32'(resp), 32'(RESP_OKAY));
    @(posedge aclk);
    pf <= 16'h012c;
    f <= 16'h012c;
    rf <= 16'h0000;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check(32'({t_out, r_out}), 32'h2);
    @(posedge aclk);
    f <= 16'h0000;
    rf <= 16'h012c;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check(32'({t_out, r_out}), 32'h1);
    $display("frequency source test done");
    run_row(ROWS[8]);
    @(posedge aclk);
    fl <= 14'h0000;
    @(posedge aclk);
    @(negedge aclk);
    check(32'(t_out), 32'h1);
    @(posedge aclk);
    @(negedge aclk);
    check(32'(t_out), 32'h0);
    $display("latency test done");
    @(posedge aclk);
    fl <= 14'h0cc4;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h0;
    @(negedge aclk);
    check(32'({t_out, r_out}), 32'h3);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check(32'({t_out, r_out}), 32'h0);
    @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    @(negedge aclk);
    check(32'({t_out, r_out}), 32'h0);
    @(posedge aclk);
    @(negedge aclk);
    check(32'({t_out, r_out}), 32'h3);
    $display("reset test done");
    for (int i = 0; i < N_OPS; i++) begin
      if (OPS[i].wr) begin
        axi_write(OPS[i].a, OPS[i].d, OPS[i].s);
      end else begin
        axi_read(OPS[i].a);
        check(rd, OPS[i].d);
      end
      check(32'(resp), 32'(OPS[i].resp));
    end
    $display("register test done");
    end_of_test();
  end
endmodule : tb_drive_status_output_select
`default_nettype wire
